// ==== pkg/fasp_map.vh ====
// Purpose: Constants of the flash host controller
// Assumes: 25 MHz mclk, word-mode flash bus
// Notes: Times in ns, cycle counts derived
`ifndef FASP_MAP_VH
`define FASP_MAP_VH

// ==========================================================
// Clock and timing
`define FASP_CLK_MHZ 25
`define FASP_T_GLITCH_NS 5
`define FASP_T_WP_NS 50
`define FASP_T_RDACC_NS 100
`define FASP_T_PWRUP_NS 1000
`define FASP_CYC_UP(ns) (((ns) * `FASP_CLK_MHZ + 999) / 1000)
`define FASP_WP_CYC `FASP_CYC_UP(`FASP_T_WP_NS)
`define FASP_RD_CYC `FASP_CYC_UP(`FASP_T_RDACC_NS)
`define FASP_PWRUP_CYC `FASP_CYC_UP(`FASP_T_PWRUP_NS)
`define FASP_SYNC_CYC 4

// ==========================================================
// User operation codes
`define FASP_OP_READ 3'h0
`define FASP_OP_WRITE 3'h1
`define FASP_OP_RESET 3'h2
`define FASP_OP_AUTOSEL 3'h3
`define FASP_OP_HVID 3'h4
`define FASP_OP_STATUS 3'h5
`define FASP_OP_UNPROT 3'h6
`define FASP_OP_TEMPUNP 3'h7

// ==========================================================
// Command cycles
`define FASP_UNLOCK1_ADDR 19'h00555
`define FASP_UNLOCK1_DATA 16'h00aa
`define FASP_UNLOCK2_ADDR 19'h002aa
`define FASP_UNLOCK2_DATA 16'h0055
`define FASP_AUTOSEL_DATA 16'h0090
`define FASP_RESET_DATA 16'h00f0

// ==========================================================
// Address fields, status bit and sector protection
`define FASP_A_SEC_HI 18
`define FASP_A_SEC_LO 12
`define FASP_A_A6 6
`define FASP_AS_PROT 2'h2
`define FASP_TIMEOUT_BIT 5
`define FASP_NSECT 19
`define FASP_PROT_RESET 19'h00000

`endif

// ==== hdl/fasp_bus_cycle.v ====
// Purpose: One flash bus cycle
// Assumes: Flash pins are asynchronous to mclk
// Notes: Pin outputs are flops
`timescale 1ns/10ps
`default_nettype none
`include "fasp_map.vh"

module fasp_bus_cycle (
    input wire mclk,
    input wire rst,
    input wire start,
    input wire wr,
    input wire hv_a9,
    input wire [18:0] addr,
    input wire [15:0] wdata,
    output reg done,
    output reg [15:0] rdata,
    output reg fl_ce_n,
    output reg fl_oe_n,
    output reg fl_we_n,
    output reg fl_a9_hv,
    output reg [18:0] fl_addr,
    output reg [15:0] fl_dq_o,
    output reg fl_dq_oe_n,
    input wire [15:0] fl_dq_i
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_SETUP = 5'h02;
    localparam [4:0] S_PULSE = 5'h04;
    localparam [4:0] S_REL = 5'h08;
    localparam [4:0] S_HOLD = 5'h10;
    localparam integer WP_CYC = `FASP_WP_CYC;
    localparam integer RD_CYC = `FASP_RD_CYC + `FASP_SYNC_CYC;

    reg [4:0] st_q;
    reg [7:0] cnt_q;
    reg wr_q;
    reg [15:0] s1_q;
    reg [15:0] s2_q;
    reg [15:0] s3_q;
    reg [15:0] acc_q;

    // ==========================================================
    // Data synchroniser; stages 2 and 3 must agree
    always @(posedge mclk) begin
        if (rst) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
            acc_q <= 16'h0000;
        end else begin
            s1_q <= fl_dq_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                acc_q <= s3_q;
            end
        end
    end

    // ==========================================================
    // Cycle sequencer
    always @(posedge mclk) begin
        if (rst) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_a9_hv <= 1'b0;
            fl_addr <= 19'h00000;
            fl_dq_o <= 16'h0000;
            fl_dq_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        // Address, data and CE change on the same edge
                        wr_q <= wr;
                        fl_addr <= addr;
                        fl_a9_hv <= hv_a9 & ~wr;
                        fl_dq_o <= wdata;
                        fl_dq_oe_n <= ~wr;
                        fl_ce_n <= 1'b0;
                        fl_oe_n <= wr; // OE high for writes
                        cnt_q <= wr ? WP_CYC[7:0] : RD_CYC[7:0];
                        st_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (wr_q) begin
                        // WE falls last
                        fl_we_n <= 1'b0;
                        st_q <= S_PULSE;
                    end else if (cnt_q == 8'h01) begin
                        rdata <= acc_q;
                        fl_oe_n <= 1'b1;
                        fl_ce_n <= 1'b1;
                        st_q <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_PULSE: begin
                    // Pulse far above glitch width
                    if (cnt_q == 8'h01) begin
                        fl_we_n <= 1'b1; // WE rises first
                        st_q <= S_REL;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_REL: begin
                    fl_ce_n <= 1'b1;
                    st_q <= S_HOLD;
                end
                S_HOLD: begin
                    fl_dq_oe_n <= 1'b1;
                    fl_a9_hv <= 1'b0;
                    done <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== hdl/fasp_ctrl.v ====
// Purpose: Flash host controller
// Assumes: Top boot block sector layout, word mode
// Notes: One operation at a time
`timescale 1ns/10ps
`default_nettype none
`include "fasp_map.vh"

module fasp_ctrl (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [18:0] cmd_addr,
    input wire [15:0] cmd_data,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg rsp_err,
    output reg [15:0] rsp_data,
    output reg all_prot,
    output reg temp_unprot,
    output reg fl_reset_n,
    output reg fl_reset_hv,
    output wire fl_ce_n,
    output wire fl_oe_n,
    output wire fl_we_n,
    output wire fl_a9_hv,
    output wire [18:0] fl_addr,
    output wire [15:0] fl_dq_o,
    output wire fl_dq_oe_n,
    input wire [15:0] fl_dq_i
);

    localparam [3:0] S_PWRUP = 4'h1;
    localparam [3:0] S_IDLE = 4'h2;
    localparam [3:0] S_ISSUE = 4'h4;
    localparam [3:0] S_WAIT = 4'h8;
    localparam integer PWRUP_CYC = `FASP_PWRUP_CYC;

    reg [3:0] st_q;
    reg [7:0] pw_q;
    reg [2:0] op_q;
    reg [18:0] addr_q;
    reg [15:0] data_q;
    reg [2:0] step_q;
    reg tout_q;
    reg [`FASP_NSECT-1:0] prot_q;
    reg cyc_start_q;
    reg cyc_wr;
    reg cyc_hv;
    reg cyc_last;
    reg [18:0] cyc_addr;
    reg [15:0] cyc_data;
    wire cyc_done;
    wire [15:0] cyc_rdata;
    wire [4:0] sec_idx;

    // ==========================================================
    // Sector index from the top address lines
    function [4:0] sector_of;
        input [18:0] a;
        begin
            if (a[18:15] != 4'hf) begin
                sector_of = {1'b0, a[18:15]};
            end else if (!a[14]) begin
                sector_of = 5'h0f;
            end else if (!a[13]) begin
                sector_of = a[12] ? 5'h11 : 5'h10;
            end else begin
                sector_of = 5'h12;
            end
        end
    endfunction

    // Protection query: offset 02h, sector on top lines
    function is_prot_query;
        input [2:0] op;
        input [18:0] a;
        begin
            is_prot_query = (op == `FASP_OP_AUTOSEL || op == `FASP_OP_HVID) &&
                (a[1:0] == `FASP_AS_PROT);
        end
    endfunction

    assign sec_idx = sector_of(addr_q);

    // ==========================================================
    // Cycle list for the current operation and step
    always @* begin
        cyc_wr = 1'b0;
        cyc_hv = 1'b0;
        cyc_last = 1'b1;
        cyc_addr = addr_q;
        cyc_data = data_q;
        case (op_q)
            `FASP_OP_WRITE, `FASP_OP_UNPROT: begin
                cyc_wr = 1'b1; // Caller gives unlocks
            end
            `FASP_OP_RESET: begin
                cyc_wr = 1'b1;
                cyc_data = `FASP_RESET_DATA; // Any address
            end
            `FASP_OP_AUTOSEL: begin
                // Unlock, enter, read, reset
                cyc_last = (step_q == 3'h4);
                case (step_q)
                    3'h0: begin
                        cyc_wr = 1'b1;
                        cyc_addr = `FASP_UNLOCK1_ADDR;
                        cyc_data = `FASP_UNLOCK1_DATA;
                    end
                    3'h1: begin
                        cyc_wr = 1'b1;
                        cyc_addr = `FASP_UNLOCK2_ADDR;
                        cyc_data = `FASP_UNLOCK2_DATA;
                    end
                    3'h2: begin
                        cyc_wr = 1'b1;
                        cyc_addr = `FASP_UNLOCK1_ADDR;
                        cyc_data = `FASP_AUTOSEL_DATA;
                    end
                    3'h3: begin
                        // Offset 00h/01h/03h/02h with sector bits
                        cyc_wr = 1'b0;
                    end
                    default: begin
                        cyc_wr = 1'b1;
                        cyc_data = `FASP_RESET_DATA; // Leave autoselect
                    end
                endcase
            end
            `FASP_OP_HVID: begin
                // A9 elevated, A6 low
                cyc_hv = 1'b1;
                cyc_addr = addr_q & ~(19'h00001 << `FASP_A_A6);
            end
            `FASP_OP_STATUS: begin
                cyc_last = (step_q == 3'h1);
                cyc_wr = (step_q == 3'h1);
                cyc_data = `FASP_RESET_DATA; // Timeout seen, reset
            end
            default: begin
                cyc_wr = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Operation sequencer
    always @(posedge mclk) begin
        if (rst) begin
            st_q <= S_PWRUP;
            pw_q <= PWRUP_CYC[7:0];
            op_q <= `FASP_OP_READ;
            addr_q <= 19'h00000;
            data_q <= 16'h0000;
            step_q <= 3'h0;
            tout_q <= 1'b0;
            prot_q <= `FASP_PROT_RESET; // Factory state
            cyc_start_q <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_data <= 16'h0000;
            all_prot <= 1'b0;
            temp_unprot <= 1'b0;
            fl_reset_n <= 1'b0;
            fl_reset_hv <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            cyc_start_q <= 1'b0;
            all_prot <= &prot_q;
            case (st_q)
                S_PWRUP: begin
                    // Controls high through power-up
                    fl_reset_n <= 1'b1;
                    if (pw_q == 8'h01) begin
                        cmd_ready <= 1'b1; // No command needed
                        st_q <= S_IDLE;
                    end else begin
                        pw_q <= pw_q - 8'h01;
                    end
                end
                S_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready <= 1'b0;
                        op_q <= cmd_op;
                        addr_q <= cmd_addr;
                        data_q <= cmd_data;
                        step_q <= 3'h0;
                        tout_q <= 1'b0;
                        if (cmd_op == `FASP_OP_TEMPUNP) begin
                            // Elevated reset pin
                            temp_unprot <= cmd_data[0];
                            fl_reset_hv <= cmd_data[0];
                            rsp_err <= 1'b0;
                            rsp_valid <= 1'b1;
                            cmd_ready <= 1'b1;
                        end else if (cmd_op == `FASP_OP_UNPROT && !(&prot_q)) begin
                            // Refuse until every sector reads protected
                            rsp_err <= 1'b1;
                            rsp_valid <= 1'b1;
                            cmd_ready <= 1'b1;
                        end else begin
                            if (cmd_op == `FASP_OP_UNPROT) begin
                                fl_reset_hv <= 1'b1;
                            end
                            st_q <= S_ISSUE;
                        end
                    end
                end
                S_ISSUE: begin
                    cyc_start_q <= 1'b1;
                    st_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (!cyc_wr) begin
                            rsp_data <= cyc_rdata;
                            if (op_q == `FASP_OP_STATUS) begin
                                tout_q <= cyc_rdata[`FASP_TIMEOUT_BIT];
                            end
                            if (is_prot_query(op_q, addr_q)) begin
                                // 01h marks protected, 00h unprotected
                                prot_q[sec_idx] <= cyc_rdata[0];
                                all_prot <= cyc_rdata[0] & (&(prot_q | (19'h00001 << sec_idx)));
                            end
                        end
                        if (cyc_last || (op_q == `FASP_OP_STATUS &&
                                !cyc_rdata[`FASP_TIMEOUT_BIT] && step_q == 3'h0)) begin
                            rsp_err <= (op_q == `FASP_OP_STATUS) && (tout_q || step_q == 3'h1);
                            rsp_valid <= 1'b1;
                            cmd_ready <= 1'b1;
                            fl_reset_hv <= temp_unprot;
                            st_q <= S_IDLE;
                        end else begin
                            step_q <= step_q + 3'h1;
                            st_q <= S_ISSUE;
                        end
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Pin-level cycle engine
    fasp_bus_cycle u_cyc (
        .mclk(mclk),
        .rst(rst),
        .start(cyc_start_q),
        .wr(cyc_wr),
        .hv_a9(cyc_hv),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n),
        .fl_a9_hv(fl_a9_hv),
        .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe_n(fl_dq_oe_n),
        .fl_dq_i(fl_dq_i)
    );

endmodule
`default_nettype wire

// ==== tb/fasp_checker.sv ====
// Purpose: Port-level assertions for the flash host controller
// Assumes: Bound to fasp_ctrl, one clock domain
// Notes: Watches what the controller drives except rsp_data, plus the cmd_valid and cmd_op requests
`timescale 1ns/10ps
`default_nettype none
`include "fasp_map.vh"
module fasp_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic all_prot,
    input wire logic temp_unprot,
    input wire logic fl_reset_n,
    input wire logic fl_reset_hv,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_a9_hv,
    input wire logic [18:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Write cycle shape and read bus contention on the flash pins
    a_write_ce_oe: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
        else $error("bad write enables");
    a_we_width: assert property ($fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n)
        else $error("write strobe width");
    a_pwrup_inhibit: assert property ($rose(fl_reset_n) |-> fl_we_n [*8])
        else $error("early write strobe");
    a_addr_stable: assert property (!fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_o))
        else $error("address or data moved");
    a_dq_hold: assert property ($rose(fl_we_n) |-> !fl_dq_oe_n && $stable(fl_dq_o))
        else $error("data not held");
    a_no_contention: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
        else $error("data bus contention");
    // ==========================================================
    // Identification, protection and unprotect requests
    a_hvid_a6: assert property (fl_a9_hv && !fl_oe_n |-> !fl_addr[6] && fl_we_n)
        else $error("bad identify read");
    a_refuse_unprot: assert property (cmd_valid && cmd_ready && cmd_op == `FASP_OP_UNPROT
        && !all_prot |=> rsp_valid && rsp_err)
        else $error("unprotect not refused");
    a_hv_follows: assert property ($past(cmd_ready) && cmd_ready
        |-> fl_reset_hv == temp_unprot)
        else $error("reset pin level wrong");
    c_write: cover property ($fell(fl_we_n));
    c_refused: cover property (rsp_valid && rsp_err);
    c_hvid: cover property (fl_a9_hv && !fl_oe_n);
    c_temp: cover property (temp_unprot);
endmodule
bind fasp_ctrl fasp_checker chk_u (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .all_prot(all_prot), .temp_unprot(temp_unprot), .fl_reset_n(fl_reset_n),
    .fl_reset_hv(fl_reset_hv), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_a9_hv(fl_a9_hv), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n));
`default_nettype wire

// ==== tb/fasp_flash_model.sv ====
// Purpose: Behavioural flash device on the controller's far side
// Assumes: Top boot sector layout, word mode, clockless pins
// Notes: Undriven data lines show the inverse of the last read
`timescale 1ns/10ps
`default_nettype none
`include "fasp_map.vh"
module fasp_flash_model #(
    parameter logic [15:0] MAKER = 16'h005c, // Arbitrary value
    parameter logic [15:0] PART = 16'h2d4e, // Arbitrary value
    parameter logic [15:0] CONT = 16'h006b // Arbitrary value
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic a9_hv,
    input wire logic reset_n,
    input wire logic reset_hv,
    input wire logic [18:0] addr,
    input wire logic [15:0] dq_in,
    input wire logic dq_oe_n,
    output logic [15:0] dq_out
);
    logic [18:0] lat_a, prot_q;
    logic [15:0] lat_d, last_q;
    logic [1:0] seq_q;
    logic as_q, tmo_q;
    int nwr, unp_bad;
    realtime t_on;
    wire wr_en = !ce_n && !we_n && oe_n && reset_n;
    wire rd = !ce_n && !oe_n && reset_n;
    // ==========================================================
    // State at power-up and hardware reset
    initial begin
        prot_q = 19'h00000;
        seq_q = 2'h0;
        as_q = 1'b0;
        tmo_q = 1'b0;
        last_q = 16'h0000;
        nwr = 0;
        unp_bad = 0;
    end
    always @(negedge reset_n) begin
        seq_q = 2'h0;
        as_q = 1'b0;
    end
    // ==========================================================
    // Write cycles: address on enable, data on release
    always @(posedge wr_en) begin
        lat_a = addr;
        t_on = $realtime;
    end
    always @(negedge wr_en) begin
        if ($realtime - t_on >= `FASP_T_GLITCH_NS) begin
            lat_d = dq_in;
            cmd(lat_a, lat_d);
        end
    end
    // Command decoder
    task automatic cmd(input logic [18:0] a, input logic [15:0] d);
        nwr++;
        if (reset_hv) begin
            if (&prot_q)
                prot_q = 19'h00000;
            else
                unp_bad++;
        end else if (d == `FASP_RESET_DATA) begin
            seq_q = 2'h0;
            as_q = 1'b0;
            tmo_q = 1'b0;
        end else if (seq_q == 2'h0 && a == `FASP_UNLOCK1_ADDR && d == `FASP_UNLOCK1_DATA)
            seq_q = 2'h1;
        else if (seq_q == 2'h1 && a == `FASP_UNLOCK2_ADDR && d == `FASP_UNLOCK2_DATA)
            seq_q = 2'h2;
        else if (seq_q == 2'h2 && a == `FASP_UNLOCK1_ADDR && d == `FASP_AUTOSEL_DATA) begin
            seq_q = 2'h0;
            as_q = 1'b1;
        end else
            seq_q = 2'h0;
    endtask
    // ==========================================================
    // Read data
    function automatic logic [4:0] sec(input logic [18:0] a);
        if (a[18:15] != 4'hf)
            sec = {1'b0, a[18:15]};
        else if (!a[14])
            sec = 5'd15;
        else if (!a[13])
            sec = a[12] ? 5'd17 : 5'd16;
        else
            sec = 5'd18;
    endfunction
    function automatic logic [15:0] rdval(input logic [18:0] a);
        if ((a9_hv && !a[6]) || as_q) begin
            case (a[1:0])
                2'h0: rdval = MAKER;
                2'h1: rdval = PART;
                2'h2: rdval = {15'h0, prot_q[sec(a)]};
                default: rdval = CONT;
            endcase
        end else
            rdval = (a[15:0] ^ 16'ha5c3) | {10'h0, tmo_q, 5'h0};
    endfunction
    always @(rd or addr or a9_hv or as_q or prot_q or tmo_q or last_q or dq_oe_n or dq_in) begin
        dq_out = rd ? rdval(addr) : (!dq_oe_n ? dq_in : ~last_q);
    end
    always @(negedge rd) begin
        last_q = rdval(addr);
    end
endmodule
`default_nettype wire

// ==== tb/tb_flash_autoselect_protect_cmd_ctrl.sv ====
// Purpose: Self-checking bench for the flash host controller
// Assumes: Behavioural flash model on the far side
// Notes: Inputs change on the falling edge of mclk
`timescale 1ns/10ps
`default_nettype none
`include "fasp_map.vh"
module tb_flash_autoselect_protect_cmd_ctrl;
    logic mclk, rst, cmd_valid;
    logic [2:0] cmd_op;
    logic [18:0] cmd_addr;
    logic [15:0] cmd_data;
    wire cmd_ready, rsp_valid, rsp_err, all_prot, temp_unprot, fl_reset_n, fl_reset_hv;
    wire fl_ce_n, fl_oe_n, fl_we_n, fl_a9_hv, fl_dq_oe_n;
    wire [15:0] rsp_data, fl_dq_o, fl_dq_i;
    wire [18:0] fl_addr;
    int fail_count = 0;
    int n_tests = 0;
    int i, n;
    // ==========================================================
    // Controller and flash model
    fasp_ctrl dut_u (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data), .all_prot(all_prot),
        .temp_unprot(temp_unprot), .fl_reset_n(fl_reset_n), .fl_reset_hv(fl_reset_hv),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_a9_hv(fl_a9_hv),
        .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i));
    fasp_flash_model flash_u (.ce_n(fl_ce_n),
        .oe_n(fl_oe_n), .we_n(fl_we_n), .a9_hv(fl_a9_hv), .reset_n(fl_reset_n),
        .reset_hv(fl_reset_hv), .addr(fl_addr), .dq_in(fl_dq_o), .dq_oe_n(fl_dq_oe_n),
        .dq_out(fl_dq_i));
    // ==========================================================
    // Shared helpers
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One request, bounded waits
    task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [15:0] d);
        int k;
        for (k = 0; k < 300 && cmd_ready !== 1'b1; k++)
            @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = o;
        cmd_addr = a;
        cmd_data = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (k < 300 && rsp_valid !== 1'b1) begin
            @(negedge mclk);
            k++;
        end
        if (k == 300) begin
            chk("response", 19'h1, 19'h0);
            end_sim();
        end
    endtask
    function automatic logic [18:0] sa(input int s);
        case (s)
            15: sa = 19'h78000;
            16: sa = 19'h7c000;
            17: sa = 19'h7d000;
            18: sa = 19'h7e000;
            default: sa = {s[3:0], 15'h0};
        endcase
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_autosel();
        flash_u.prot_q = 19'h00020;
        op(`FASP_OP_AUTOSEL, 19'h7ff00, 16'h0);
        chk("as maker", flash_u.MAKER, rsp_data);
        op(`FASP_OP_AUTOSEL, 19'h00001, 16'h0);
        chk("as part", flash_u.PART, rsp_data);
        op(`FASP_OP_AUTOSEL, 19'h00003, 16'h0);
        chk("as cont", flash_u.CONT, rsp_data);
        op(`FASP_OP_AUTOSEL, sa(5) | 19'h2, 16'h0);
        chk("as prot", 19'h1, rsp_data);
        op(`FASP_OP_AUTOSEL, sa(6) | 19'h2, 16'h0);
        chk("as unprot", 19'h0, rsp_data);
        chk("as mode left", 19'h0, flash_u.as_q);
    endtask
    task automatic t_hvid_unprot();
        op(`FASP_OP_HVID, 19'h00040, 16'h0);
        chk("hv maker", flash_u.MAKER, rsp_data);
        op(`FASP_OP_HVID, 19'h00001, 16'h0);
        chk("hv part", flash_u.PART, rsp_data);
        op(`FASP_OP_HVID, 19'h00003, 16'h0);
        chk("hv cont", flash_u.CONT, rsp_data);
        n = flash_u.nwr;
        op(`FASP_OP_UNPROT, sa(3), 16'h0);
        chk("unprot refused", 19'h1, rsp_err);
        chk("no bus write", 19'(n), 19'(flash_u.nwr));
        flash_u.prot_q = 19'h7ffff;
        for (i = 0; i < 19; i++) begin
            op(`FASP_OP_HVID, sa(i) | 19'h2, 16'h0);
            chk("hv sector prot", 19'h1, rsp_data);
        end
        @(negedge mclk);
        chk("all protected", 19'h1, all_prot);
        op(`FASP_OP_UNPROT, sa(3), 16'h0);
        chk("unprot taken", 19'h0, rsp_err);
        chk("unprot order", 19'h0, 19'(flash_u.unp_bad));
        op(`FASP_OP_HVID, sa(3) | 19'h2, 16'h0);
        chk("now unprot", 19'h0, rsp_data);
    endtask
    task automatic t_write_seq();
        op(`FASP_OP_WRITE, 19'h2c3a5, 16'h3c5a);
        chk("latched addr", 19'h2c3a5, flash_u.lat_a);
        chk("latched data", 19'h03c5a, flash_u.lat_d);
        op(`FASP_OP_WRITE, `FASP_UNLOCK1_ADDR, `FASP_UNLOCK1_DATA);
        op(`FASP_OP_WRITE, 19'h00123, 16'h0077);
        chk("bad sequence", 19'h0, flash_u.seq_q);
        op(`FASP_OP_WRITE, `FASP_UNLOCK1_ADDR, `FASP_UNLOCK1_DATA);
        op(`FASP_OP_WRITE, `FASP_UNLOCK2_ADDR, `FASP_UNLOCK2_DATA);
        op(`FASP_OP_WRITE, `FASP_UNLOCK1_ADDR, `FASP_AUTOSEL_DATA);
        op(`FASP_OP_READ, 19'h00001, 16'h0);
        chk("raw as part", flash_u.PART, rsp_data);
        op(`FASP_OP_RESET, 19'h5a5a5, 16'h0);
        op(`FASP_OP_READ, 19'h00001, 16'h0);
        chk("array again", 19'h0a5c2, rsp_data);
    endtask
    task automatic t_status_temp();
        flash_u.tmo_q = 1'b1;
        op(`FASP_OP_STATUS, 19'h00100, 16'h0);
        chk("status err", 19'h1, rsp_err);
        chk("status data", 19'h0a4e3, rsp_data);
        chk("timeout cleared", 19'h0, flash_u.tmo_q);
        op(`FASP_OP_STATUS, 19'h00100, 16'h0);
        chk("status ok", 19'h0, rsp_err);
        op(`FASP_OP_TEMPUNP, 19'h0, 16'h0001);
        @(negedge mclk);
        chk("temp set", 19'h1, {temp_unprot, fl_reset_hv} == 2'b11);
        op(`FASP_OP_TEMPUNP, 19'h0, 16'h0000);
        @(negedge mclk);
        chk("temp clear", 19'h0, {temp_unprot, fl_reset_hv});
    endtask
    // ==========================================================
    // Clock, reset and main sequence
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_addr = 19'h0;
        cmd_data = 16'h0;
        repeat (6) @(negedge mclk);
        chk("we in reset", 19'h1, fl_we_n);
        chk("device reset", 19'h0, fl_reset_n);
        rst = 1'b0;
        op(`FASP_OP_READ, 19'h12345, 16'h0);
        chk("power-up read", 19'h08686, rsp_data);
        t_autosel();
        t_hvid_unprot();
        t_write_seq();
        t_status_temp();
        end_sim();
    end
endmodule
`default_nettype wire
